// file: rtl/rrc_pkg.sv
// Shared constants and types for the reset and stop-recovery sequencer.
// Assumes a single 125 MHz APB clock; nothing else is shared.
`default_nettype none
package rrc_pkg;

  // Clock and pin filter timing
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned STOP_GLITCH_NS  = 12;
  // Least time, so round up to whole cycles
  localparam int unsigned STOP_PIN_CYC    = (STOP_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RUN_PIN_CYC     = 4;
  localparam int unsigned PIN_CNT_W       = 3;

  // Reset latency in internal oscillator cycles
  localparam int unsigned LAT_SHORT_IOSC  = 66;
  localparam int unsigned LAT_LONG_IOSC   = 5000;
  localparam int unsigned LAT_W           = 13;

  // APB register byte addresses
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] ADDR_CAUSE      = 12'h000;
  localparam logic [11:0] ADDR_OPTION     = 12'h004;
  localparam logic [11:0] ADDR_DEBUG_CTL  = 12'h008;
  localparam logic [11:0] ADDR_STATE      = 12'h00C;
  localparam logic [11:0] ADDR_LATENCY    = 12'h010;

  // Reset cause field: bits 7..4 of its register
  localparam int unsigned CAUSE_LSB       = 4;
  localparam logic [3:0]  CAUSE_POWER     = 4'h8;
  localparam logic [3:0]  CAUSE_STOP      = 4'h4;
  localparam logic [3:0]  CAUSE_WATCHDOG  = 4'h2;
  localparam logic [3:0]  CAUSE_PIN       = 4'h1;
  localparam logic [3:0]  CAUSE_RESET     = 4'h8;

  // Option register fields
  localparam int unsigned OPT_XTAL        = 0;
  localparam int unsigned OPT_WD_ACTION   = 1;
  localparam int unsigned OPT_BO_KEEP     = 2;
  localparam logic [7:0]  OPT_MASK        = 8'h07;
  localparam logic [7:0]  OPT_RESET       = 8'h02;

  // Debugger control register field
  localparam int unsigned DEBUG_RST_BIT   = 0;

  // State register fields
  localparam int unsigned ST_IN_RESET     = 0;
  localparam int unsigned ST_PIN_LEVEL    = 1;
  localparam int unsigned ST_SUPPLY_OK    = 2;
  localparam int unsigned ST_RECOVERY     = 3;
  localparam int unsigned ST_WAIT_PIN     = 4;

  // Synchroniser lanes
  localparam int unsigned SY_PIN          = 0;
  localparam int unsigned SY_SUPPLY       = 1;
  localparam int unsigned SY_BROWN        = 2;
  localparam int unsigned SY_DEBUG        = 3;
  localparam int unsigned SY_W            = 4;
  localparam logic [3:0]  SY_RESET        = 4'h9;

  // Reset vector locations
  localparam logic [15:0] VEC_ADDR_LO     = 16'h0002;
  localparam logic [15:0] VEC_ADDR_HI     = 16'h0003;

  typedef enum logic [1:0] {st_run, st_supply, st_count, st_pin} rrc_state_type;
  typedef enum logic [1:0] {k_sys, k_pin, k_smr} rrc_kind_type;

endpackage
`default_nettype wire

// file: rtl/rrc_reset_ctrl.sv
// Reset and stop-recovery sequencer with APB status and option registers.
// Assumes APB on pclk; analog detectors, watchdog and GPIO logic sit outside.
//
// Our own choices: register access over APB and the register addresses.
`default_nettype none
module rrc_reset_ctrl
#(
  parameter int unsigned IOSC_DIV  = 1,                      // pclk cycles per osc cycle
  parameter int unsigned LAT_SHORT = rrc_pkg::LAT_SHORT_IOSC, // Plain latency, osc cycles
  parameter int unsigned LAT_LONG  = rrc_pkg::LAT_LONG_IOSC   // Crystal latency, osc cycles
)
(
  input  wire logic        pclk,                        // System clock
  input  wire logic        presetn,                     // Async reset, active low
  input  wire logic [11:0] paddr,                       // APB address
  input  wire logic        psel,                        // APB select
  input  wire logic        penable,                     // APB enable
  input  wire logic        pwrite,                      // APB direction
  input  wire logic [31:0] pwdata,                      // APB write data
  output logic      [31:0] prdata,                      // APB read data
  output logic             pready,                      // APB ready
  output logic             pslverr,                     // APB error
  input  wire logic        supply_good,                 // Supply above power-on level
  input  wire logic        brownout_detector,           // Supply below safe level
  input  wire logic        watchdog_timeout,            // Watchdog time-out pulse
  input  wire logic        stop_mode,                   // Device is in stop mode
  input  wire logic        stop_wake_event,             // Enabled GPIO transition pulse
  input  wire logic        debug_serial_pin,            // Debug pin level, low = reset in stop mode
  input  wire logic        shared_reset_port_pin_i,     // Reset pin level
  output logic             shared_reset_port_pin_o,     // Reset pin drive value
  output logic             shared_reset_port_pin_oe_n,  // Reset pin drive enable, low
  output logic             cpu_reset_n,                 // CPU held in reset, low
  output logic             ctl_reg_reset_n,             // Control regs and GPIO reset, low
  output logic             watchdog_osc_reset_n,        // Watchdog/osc control reset, low
  output logic             clk_src_iosc_force,          // Select internal oscillator
  output logic             xtal_run_en,                 // Crystal oscillator enable
  output logic             brownout_enable,             // Brown-out detector enable
  output logic             vector_fetch,                // One-cycle vector fetch strobe
  output logic      [15:0] vector_addr_lo,              // Vector low byte location
  output logic      [15:0] vector_addr_hi,              // Vector high byte location
  output logic             watchdog_irq                 // Watchdog interrupt pulse
);

  localparam int unsigned DIV_W = (IOSC_DIV < 2) ? 1 : $clog2(IOSC_DIV);

  if (IOSC_DIV < 1)
  begin : g_bad_div
    $error("IOSC_DIV must be at least 1");
  end
  if (LAT_SHORT < 1 || LAT_SHORT > LAT_LONG)
  begin : g_bad_short
    $error("LAT_SHORT must be 1 .. LAT_LONG");
  end
  if (LAT_LONG >= (1 << rrc_pkg::LAT_W))
  begin : g_bad_long
    $error("LAT_LONG does not fit the latency counter");
  end

  typedef struct packed {
    rrc_pkg::rrc_state_type          st;
    rrc_pkg::rrc_kind_type           kind;
    logic [rrc_pkg::LAT_W-1:0]       lat;
    logic [DIV_W-1:0]                div;
    logic [rrc_pkg::PIN_CNT_W-1:0]   low_cnt;
    logic [3:0]                      cause;
    logic [7:0]                      opt;
    logic                            debug_req;
    logic                            vec_go;
    logic                            wd_irq;
    logic [31:0]                     rdata;
    logic                            slverr;
  } rrc_ctl_type;

  localparam rrc_ctl_type CTL_RESET = '{
    st:        rrc_pkg::st_supply,
    kind:      rrc_pkg::k_sys,
    lat:       '0,
    div:       '0,
    low_cnt:   '0,
    cause:     rrc_pkg::CAUSE_RESET,
    opt:       rrc_pkg::OPT_RESET,
    debug_req: 1'b0,
    vec_go:    1'b0,
    wd_irq:    1'b0,
    rdata:     '0,
    slverr:    1'b0
  };

  rrc_ctl_type                   r;
  rrc_ctl_type                   n;
  logic [rrc_pkg::SY_W-1:0]      sync_q;
  logic                          pin_hi;
  logic                          supply_ok;
  logic                          tick;
  logic                          bo_live;
  logic                          supply_bad;
  logic [rrc_pkg::PIN_CNT_W-1:0] pin_thr;
  logic                          pin_hit;
  logic                          in_reset;
  logic [rrc_pkg::LAT_W-1:0]     lat_load;
  logic                          setup;
  logic                          access;
  logic                          mapped;
  logic [31:0]                   rd_mux;

  // Raw pin levels are asynchronous to pclk
  rrc_sync
  #(
    .WIDTH     (rrc_pkg::SY_W),
    .RESET_VAL (rrc_pkg::SY_RESET)
  )
  u_sync
  (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({debug_serial_pin, brownout_detector, supply_good, shared_reset_port_pin_i}),
    .q     (sync_q)
  );

  assign pin_hi    = sync_q[rrc_pkg::SY_PIN];
  assign supply_ok = sync_q[rrc_pkg::SY_SUPPLY];
  assign tick      = (r.div == DIV_W'(IOSC_DIV - 1));
  assign bo_live   = !stop_mode || r.opt[rrc_pkg::OPT_BO_KEEP];
  assign supply_bad = !supply_ok || (sync_q[rrc_pkg::SY_BROWN] && bo_live);
  assign in_reset  = (r.st != rrc_pkg::st_run);

  // Stop mode only has the analog glitch filter, so the bar is lower
  assign pin_thr = stop_mode ? rrc_pkg::PIN_CNT_W'(rrc_pkg::STOP_PIN_CYC)
                             : rrc_pkg::PIN_CNT_W'(rrc_pkg::RUN_PIN_CYC);
  assign pin_hit = !pin_hi && (r.low_cnt >= pin_thr - rrc_pkg::PIN_CNT_W'(1));

  assign lat_load = r.opt[rrc_pkg::OPT_XTAL] ? rrc_pkg::LAT_W'(LAT_LONG - 1)
                                             : rrc_pkg::LAT_W'(LAT_SHORT - 1);

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == rrc_pkg::ADDR_CAUSE) || (paddr == rrc_pkg::ADDR_OPTION) ||
                  (paddr == rrc_pkg::ADDR_DEBUG_CTL) || (paddr == rrc_pkg::ADDR_STATE) ||
                  (paddr == rrc_pkg::ADDR_LATENCY);

  always_comb
  begin
    rd_mux = '0;
    unique case (paddr)
      rrc_pkg::ADDR_CAUSE:
      begin
        rd_mux[rrc_pkg::CAUSE_LSB +: 4] = r.cause;
      end
      rrc_pkg::ADDR_OPTION:
      begin
        rd_mux[7:0] = r.opt;
      end
      rrc_pkg::ADDR_DEBUG_CTL:
      begin
        rd_mux[rrc_pkg::DEBUG_RST_BIT] = r.debug_req;
      end
      rrc_pkg::ADDR_STATE:
      begin
        rd_mux[rrc_pkg::ST_IN_RESET]  = in_reset;
        rd_mux[rrc_pkg::ST_PIN_LEVEL] = pin_hi;
        rd_mux[rrc_pkg::ST_SUPPLY_OK] = supply_ok;
        rd_mux[rrc_pkg::ST_RECOVERY]  = in_reset && (r.kind == rrc_pkg::k_smr);
        rd_mux[rrc_pkg::ST_WAIT_PIN]  = (r.st == rrc_pkg::st_pin);
      end
      rrc_pkg::ADDR_LATENCY:
      begin
        rd_mux[rrc_pkg::LAT_W-1:0] = r.lat;
      end
      default:
      begin
        rd_mux = '0;
      end
    endcase
  end

  always_comb
  begin
    logic                  go;
    rrc_pkg::rrc_kind_type go_kind;
    logic [3:0]            go_cause;
    go       = 1'b0;
    go_kind  = rrc_pkg::k_sys;
    go_cause = r.cause;
    n        = r;
    n.vec_go = 1'b0;
    n.wd_irq = 1'b0;
    n.div    = tick ? '0 : r.div + DIV_W'(1);

    // Read data is captured in the setup cycle, shown in the access cycle
    if (setup)
    begin
      n.rdata  = rd_mux;
      n.slverr = !mapped;
    end
    if (access && pwrite && paddr == rrc_pkg::ADDR_OPTION)
    begin
      n.opt = pwdata[7:0] & rrc_pkg::OPT_MASK;
    end
    if (access && pwrite && paddr == rrc_pkg::ADDR_DEBUG_CTL)
    begin
      n.debug_req = pwdata[rrc_pkg::DEBUG_RST_BIT];
    end
    // Clear only what was returned; a cause set meanwhile survives
    if (access && !pwrite && paddr == rrc_pkg::ADDR_CAUSE)
    begin
      n.cause = r.cause & ~r.rdata[rrc_pkg::CAUSE_LSB +: 4];
    end

    // Pin low-time counter, only meaningful while running
    if (r.st == rrc_pkg::st_run && !pin_hi)
    begin
      if (r.low_cnt != '1)
      begin
        n.low_cnt = r.low_cnt + rrc_pkg::PIN_CNT_W'(1);
      end
    end
    else
    begin
      n.low_cnt = '0;
    end

    unique case (r.st)
      rrc_pkg::st_run:
      begin
        if (pin_hit)
        begin
          go       = 1'b1;
          go_kind  = rrc_pkg::k_pin;
          go_cause = rrc_pkg::CAUSE_PIN;
        end
        else if ((!stop_mode && r.debug_req) || (stop_mode && !sync_q[rrc_pkg::SY_DEBUG]))
        begin
          go       = 1'b1;
          go_kind  = rrc_pkg::k_sys;
          go_cause = rrc_pkg::CAUSE_POWER;
        end
        else if (watchdog_timeout && stop_mode)
        begin
          go       = 1'b1;
          go_kind  = rrc_pkg::k_smr;
          go_cause = rrc_pkg::CAUSE_STOP | rrc_pkg::CAUSE_WATCHDOG;
        end
        else if (watchdog_timeout && r.opt[rrc_pkg::OPT_WD_ACTION])
        begin
          go       = 1'b1;
          go_kind  = rrc_pkg::k_sys;
          go_cause = rrc_pkg::CAUSE_WATCHDOG;
        end
        else if (stop_mode && stop_wake_event)
        begin
          go       = 1'b1;
          go_kind  = rrc_pkg::k_smr;
          go_cause = rrc_pkg::CAUSE_STOP;
        end
        // Interrupt-configured time-out keeps the watchdog flag as well
        if (watchdog_timeout && !r.opt[rrc_pkg::OPT_WD_ACTION])
        begin
          n.wd_irq = 1'b1;
          if (!go)
          begin
            n.cause = n.cause | rrc_pkg::CAUSE_WATCHDOG;
          end
        end
      end
      rrc_pkg::st_supply:
      begin
        if (!supply_bad)
        begin
          n.st  = rrc_pkg::st_count;
          n.lat = lat_load;
        end
      end
      rrc_pkg::st_count:
      begin
        if (tick)
        begin
          if (r.lat != '0)
          begin
            n.lat = r.lat - rrc_pkg::LAT_W'(1);
          end
          else if (r.kind == rrc_pkg::k_pin && !pin_hi)
          begin
            n.st = rrc_pkg::st_pin;
          end
          else
          begin
            n.st     = rrc_pkg::st_run;
            n.vec_go = 1'b1;
          end
        end
      end
      rrc_pkg::st_pin:
      begin
        if (pin_hi)
        begin
          n.st     = rrc_pkg::st_run;
          n.vec_go = 1'b1;
        end
      end
    endcase

    if (go)
    begin
      n.st    = rrc_pkg::st_count;
      n.kind  = go_kind;
      n.cause = go_cause;
      n.lat   = lat_load;
      if (go_kind != rrc_pkg::k_smr)
      begin
        n.debug_req = 1'b0;
      end
    end

    // Power trouble overrides everything and restarts the full sequence
    if (supply_bad)
    begin
      n.st        = rrc_pkg::st_supply;
      n.kind      = rrc_pkg::k_sys;
      n.cause     = rrc_pkg::CAUSE_POWER;
      n.vec_go    = 1'b0;
      n.debug_req = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= CTL_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = r.rdata;
  assign pslverr = r.slverr;

  // CPU held in every kind of reset; oscillators are never gated here
  assign cpu_reset_n          = !in_reset;
  // Stop recovery keeps control registers; debugger has no reset from here
  assign ctl_reg_reset_n      = !(in_reset && r.kind != rrc_pkg::k_smr);
  assign watchdog_osc_reset_n = !in_reset;
  assign clk_src_iosc_force   = in_reset;
  assign xtal_run_en          = r.opt[rrc_pkg::OPT_XTAL];
  assign brownout_enable      = bo_live;

  // Not driven for a pin reset: our own low would mask the release
  assign shared_reset_port_pin_o    = 1'b0;
  assign shared_reset_port_pin_oe_n = !((r.st == rrc_pkg::st_supply ||
                                         r.st == rrc_pkg::st_count) &&
                                        r.kind != rrc_pkg::k_pin);

  assign vector_fetch   = r.vec_go;
  assign vector_addr_lo = rrc_pkg::VEC_ADDR_LO;
  assign vector_addr_hi = rrc_pkg::VEC_ADDR_HI;
  assign watchdog_irq   = r.wd_irq;

endmodule // rrc_reset_ctrl
`default_nettype wire

// file: rtl/rrc_sync.sv
// Two-flop synchroniser, one lane per bit.
// Assumes the inputs change freely with respect to clk.
`default_nettype none
module rrc_sync
#(
  parameter int unsigned       WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
)
(
  input  wire logic             clk,    // Sampling clock
  input  wire logic             rst_n,  // Async reset, active low
  input  wire logic [WIDTH-1:0] d,      // Raw inputs
  output logic      [WIDTH-1:0] q       // Synchronised outputs
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } rrc_sync_type;

  rrc_sync_type r;
  rrc_sync_type n;

  // First stage feeds only the second stage
  always_comb
  begin
    n    = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '{s1: RESET_VAL, s2: RESET_VAL};
    end
    else
    begin
      r <= n;
    end
  end

  assign q = r.s2;

endmodule // rrc_sync
`default_nettype wire

// file: sim/rrc_reset_ctrl_sva.sv
// Port checker for the reset sequencer.
// Assumes it is bound to rrc_reset_ctrl and sees its pclk domain only.
`default_nettype none
module rrc_reset_ctrl_sva
#(
  parameter int unsigned LAT_SHORT = 66 // Short latency, osc cycles
)
(
  input wire logic        pclk,                       // Clock
  input wire logic        presetn,                    // Reset, low
  input wire logic        psel,                       // APB select
  input wire logic        penable,                    // APB enable
  input wire logic        pready,                     // APB ready
  input wire logic        stop_mode,                  // Stop mode
  input wire logic        watchdog_timeout,           // Watchdog pulse
  input wire logic        shared_reset_port_pin_o,    // Pin value
  input wire logic        shared_reset_port_pin_oe_n, // Pin enable, low
  input wire logic        cpu_reset_n,                // CPU reset, low
  input wire logic        ctl_reg_reset_n,            // Control reset, low
  input wire logic        watchdog_osc_reset_n,       // Wdog/osc reset, low
  input wire logic        clk_src_iosc_force,         // Clock force
  input wire logic        brownout_enable,            // Brown-out enable
  input wire logic        vector_fetch,               // Fetch strobe
  input wire logic [15:0] vector_addr_lo,             // Vector low
  input wire logic [15:0] vector_addr_hi,             // Vector high
  input wire logic        watchdog_irq                // Watchdog irq
);
  logic [15:0] low_r;

  // Saturates so a very long hold cannot wrap
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_r <= 16'h0000;
    else if (cpu_reset_n) low_r <= 16'h0000;
    else if (low_r != 16'hFFFF) low_r <= low_r + 16'h0001;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence fetch_s;
    vector_fetch ##1 !vector_fetch;
  endsequence

  AST_HOLD_MIN: assert property ($rose(cpu_reset_n) |-> low_r >= LAT_SHORT)
    else $error("reset hold too short");
  AST_VEC_FETCH: assert property ($rose(cpu_reset_n) |-> fetch_s)
    else $error("no single fetch strobe at release");
  AST_VEC_ADDR: assert property (vector_addr_lo == 16'h0002 && vector_addr_hi == 16'h0003)
    else $error("vector locations wrong");
  AST_IOSC: assert property (!watchdog_osc_reset_n |-> clk_src_iosc_force)
    else $error("clock not forced in reset");
  AST_CTL_CPU: assert property (!ctl_reg_reset_n |-> !cpu_reset_n)
    else $error("control reset without cpu reset");
  AST_OD_LOW: assert property (
    !shared_reset_port_pin_oe_n |-> !shared_reset_port_pin_o && !cpu_reset_n)
    else $error("pin driven outside reset");
  AST_ENTRY: assert property ($fell(cpu_reset_n) |-> !watchdog_osc_reset_n)
    else $error("wdog/osc control not reset");
  AST_BO_RUN: assert property (!stop_mode |-> brownout_enable)
    else $error("brown-out off outside stop");
  AST_WD_ACT: assert property (
    cpu_reset_n && watchdog_timeout && !stop_mode |=> !cpu_reset_n || watchdog_irq)
    else $error("watchdog time-out lost");
  AST_IRQ_SRC: assert property (watchdog_irq |-> $past(watchdog_timeout))
    else $error("irq without time-out");
  AST_APB_READY: assert property (psel && penable |-> pready)
    else $error("access phase not answered");
endmodule // rrc_reset_ctrl_sva
`default_nettype wire

// file: sim/rrc_reset_ctrl_tb.sv
// Self-checking bench for the reset sequencer with a shared reset line.
// Assumes latencies shortened to 5 and 20, one oscillator cycle per clock.
`default_nettype none
module rrc_reset_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LS = 5;
  localparam int LL = 20;
  typedef struct {int kind; logic stop; logic [7:0] opt; logic [7:0] cause;
    logic [3:0] lo; logic [3:0] m; int lmin; int lmax;} rrc_row_type;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        supply_good, brownout_detector, watchdog_timeout, stop_mode, stop_wake_event;
  logic        debug_serial_pin, shared_reset_port_pin_i, shared_reset_port_pin_o;
  logic        shared_reset_port_pin_oe_n, cpu_reset_n, ctl_reg_reset_n, watchdog_osc_reset_n;
  logic        clk_src_iosc_force, xtal_run_en, brownout_enable, vector_fetch, watchdog_irq;
  logic [15:0] vector_addr_lo, vector_addr_hi;
  logic        pstart;
  logic [7:0]  plen;
  int          err_count, tests_run;

  // kind: 0 pin, 1 debug register, 2 watchdog, 3 brown-out, 4 wake, 5 debug pin
  // lo: lowest {oe_n, ctl, wdog/osc, clock force} seen while held; m masks it
  rrc_row_type rows [9] = '{
    '{0, 0, 8'h02, 8'h10, 4'h9, 4'hF, LS, LS+3}, '{1, 0, 8'h02, 8'h80, 4'h1, 4'h7, LS, LS+3},
    '{2, 0, 8'h02, 8'h20, 4'h1, 4'hF, LS, LS+3}, '{2, 0, 8'h03, 8'h20, 4'h1, 4'hF, LL, LL+3},
    '{3, 0, 8'h02, 8'h80, 4'h1, 4'hF, LS+2, LS+12}, '{4, 1, 8'h02, 8'h40, 4'h5, 4'h7, LS, LS+3},
    '{2, 1, 8'h02, 8'h60, 4'h5, 4'h7, LS, LS+3}, '{5, 1, 8'h02, 8'h80, 4'h1, 4'h7, LS, LS+3},
    '{0, 1, 8'h02, 8'h10, 4'h9, 4'hF, LS, LS+3}};

  rrc_reset_ctrl #(.IOSC_DIV(1), .LAT_SHORT(LS), .LAT_LONG(LL)) uut (.*);
  rrc_reset_line line (.pclk(pclk), .start(pstart), .len(plen), .dev_o(shared_reset_port_pin_o),
    .dev_oe_n(shared_reset_port_pin_oe_n), .pin(shared_reset_port_pin_i));

  task automatic chk_word(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int lo, input int hi, input int g);
    tests_run++;
    if (g < lo || g > hi)
    begin
      err_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Starts and ends just after a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe, input string nm);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b0, 32'h0000_0000, q, e);
    chk_word(nm, x, q);
    chk_word({nm, " error"}, {31'h0, xe}, {31'h0, e});
  endtask

  // Counts held cycles; pulse triggers drop at cycle 0, brown-out, debug pin and stop mode at cycle hold
  task automatic watch(input int hold, output int n, output logic [3:0] lo);
    logic seen;
    n = 0;
    seen = 1'b0;
    lo = 4'hF;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge pclk);
      if (i == 0) {pstart, watchdog_timeout, stop_wake_event} <= 3'h0;
      if (i == hold) {brownout_detector, debug_serial_pin, stop_mode} <= 3'h2;
      if (cpu_reset_n === 1'b0)
      begin
        n++;
        seen = 1'b1;
        lo = lo & {shared_reset_port_pin_oe_n, ctl_reg_reset_n, watchdog_osc_reset_n,
                   clk_src_iosc_force};
      end
      else if (seen) break;
    end
    chk_word("vector_fetch", 32'h1, {31'h0, vector_fetch});
  endtask

  task automatic glitch(input logic s, input logic [7:0] l);
    logic hit;
    hit = 1'b0;
    stop_mode <= s;
    plen <= l;
    pstart <= 1'b1;
    @(posedge pclk);
    pstart <= 1'b0;
    repeat (12)
    begin
      @(posedge pclk);
      hit = hit | (cpu_reset_n !== 1'b1);
    end
    stop_mode <= 1'b0;
    @(posedge pclk);
    chk_word("glitch reset", 32'h0, {31'h0, hit});
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial
  begin
    #100000;
    err_count++;
    test_done;
  end

  initial
  begin
    int          n;
    logic [31:0] q;
    logic [3:0]  lo;
    logic        e, hit, irq;
    {presetn, psel, penable, pwrite, supply_good, brownout_detector} = 6'h00;
    {watchdog_timeout, stop_mode, stop_wake_event, pstart} = 4'h0;
    debug_serial_pin = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    plen = 8'd6;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    chk_word("held for supply", 32'h0, {31'h0, cpu_reset_n});
    supply_good <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (cpu_reset_n !== 1'b1 && n < 200);
    chk_cnt("power latency", LS, LS + 6, n);
    rdc(rrc_pkg::ADDR_CAUSE, 32'h0000_0080, 1'b0, "cause");
    rdc(rrc_pkg::ADDR_CAUSE, 32'h0000_0000, 1'b0, "cause");
    rdc(rrc_pkg::ADDR_OPTION, 32'h0000_0002, 1'b0, "option");
    rdc(12'h040, 32'h0000_0000, 1'b1, "unmapped");
    $display("power-up test done");
    foreach (rows[k])
    begin
      apb(rrc_pkg::ADDR_OPTION, 1'b1, {24'h0, rows[k].opt}, q, e);
      chk_word("xtal_run_en", {31'h0, rows[k].opt[0]}, {31'h0, xtal_run_en});
      stop_mode <= rows[k].stop;
      @(posedge pclk);
      if (rows[k].kind == 1) apb(rrc_pkg::ADDR_DEBUG_CTL, 1'b1, 32'h0000_0001, q, e);
      pstart <= (rows[k].kind == 0);
      watchdog_timeout <= (rows[k].kind == 2);
      brownout_detector <= (rows[k].kind == 3);
      stop_wake_event <= (rows[k].kind == 4);
      debug_serial_pin <= (rows[k].kind != 5);
      watch(6, n, lo);
      chk_cnt("hold", rows[k].lmin, rows[k].lmax, n);
      chk_word("levels", {28'h0, rows[k].lo & rows[k].m}, {28'h0, lo & rows[k].m});
      rdc(rrc_pkg::ADDR_CAUSE, {24'h0, rows[k].cause}, 1'b0, "cause");
      $display("row %0d done", k);
    end
    glitch(1'b0, 8'd2);
    glitch(1'b1, 8'd1);
    plen <= 8'd30;
    pstart <= 1'b1;
    @(posedge pclk);
    pstart <= 1'b0;
    repeat (20) @(posedge pclk);
    chk_word("held by pin", 32'h0, {31'h0, cpu_reset_n});
    n = 0;
    do @(posedge pclk); while (shared_reset_port_pin_i !== 1'b1 && ++n < 40);
    n = 0;
    do begin @(posedge pclk); n++; end while (cpu_reset_n !== 1'b1 && n < 20);
    chk_cnt("pin release", 1, 5, n);
    rdc(rrc_pkg::ADDR_CAUSE, 32'h0000_0010, 1'b0, "cause");
    $display("pin tests done");
    apb(rrc_pkg::ADDR_OPTION, 1'b1, 32'h0000_0000, q, e);
    watchdog_timeout <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
    {hit, irq} = 2'b00;
    repeat (4)
    begin
      @(posedge pclk);
      irq = irq | (watchdog_irq === 1'b1);
      hit = hit | (cpu_reset_n !== 1'b1);
    end
    chk_word("irq and reset", 32'h2, {30'h0, irq, hit});
    rdc(rrc_pkg::ADDR_CAUSE, 32'h0000_0020, 1'b0, "cause");
    stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_word("bo enable", 32'h0, {31'h0, brownout_enable});
    apb(rrc_pkg::ADDR_OPTION, 1'b1, 32'h0000_0004, q, e);
    chk_word("bo enable", 32'h1, {31'h0, brownout_enable});
    stop_mode <= 1'b0;
    rdc(rrc_pkg::ADDR_DEBUG_CTL, 32'h0000_0000, 1'b0, "debug ctl");
    $display("option tests done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_word("reset levels", 32'h1, {28'h0, shared_reset_port_pin_oe_n, ctl_reg_reset_n,
             watchdog_osc_reset_n, clk_src_iosc_force});
    rdc(rrc_pkg::ADDR_OPTION, 32'h0000_0002, 1'b0, "option");
    $display("reset test done");
    test_done;
  end
endmodule // rrc_reset_ctrl_tb

bind rrc_reset_ctrl rrc_reset_ctrl_sva #(.LAT_SHORT(LAT_SHORT)) chk (.*);
`default_nettype wire

// file: sim/rrc_reset_line.sv
// Far side of the shared reset line: external driver plus pull-up.
// Assumes start is a one-cycle pulse; len is the low width in clocks.
`default_nettype none
module rrc_reset_line
(
  input  wire logic       pclk,     // System clock
  input  wire logic       start,    // Begin a low pulse
  input  wire logic [7:0] len,      // Low width, clocks
  input  wire logic       dev_o,    // Device drive value
  input  wire logic       dev_oe_n, // Device drive enable, low
  output logic            pin       // Resolved line level
);
  logic [7:0] cnt_r = 8'h00;

  always @(posedge pclk)
    if (start) cnt_r <= len;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;

  // Open drain: pull-up wins unless a party pulls low
  assign pin = !((cnt_r != 8'h00) || (!dev_oe_n && !dev_o));
endmodule // rrc_reset_line
`default_nettype wire
